/* File: design/serial_register_port.sv */
// I2C / SPI register access port with SDA timeout detection
`timescale 1ns/1ps
`default_nettype none
`include "serial_register_port_cfg.svh"
module serial_register_port #(
  parameter int         TIMEOUT_CYCLES = `SDA_TIMEOUT_US * `REF_CLK_MHZ,
  parameter logic [4:0] FIXED_ADDR     = `FIXED_ADDR_RESET
) (
  input  wire logic      ref_clk,
  input  wire logic      resetn,
  input  wire logic      serialClk,
  input  wire logic      chipSelectN,
  input  wire logic      interfaceSelect,
  input  wire logic      addressPinHigh,
  input  wire logic      addressPinLow,
  input  wire logic      sdioIn,
  output logic           sdioOut,
  output logic           sdioOe,
  output logic           sdoOut,
  output logic           sdoOe,
  output srp_pkg::regs_s regState
);
  import srp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register read decode
  function automatic logic [7:0] readReg(input regs_s r, input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == `REG_PAGE)
      d = r.page;
    else
      case ({r.page, a})
        `ADDR_BUS_TARGET: d = {1'b0, r.busTargetAddress};
        `ADDR_TMO_IND:    d[`TMO_BIT] = r.timeoutIndicator;
        `ADDR_TMO_FLAG:   d[`TMO_BIT] = r.timeoutStickyFlag;
        `ADDR_WIRE3:      d[`WIRE3_BIT] = r.spiWireCountSelect;
        `ADDR_IO_VDD:     d[`IO_VDD_BIT] = r.ioVoltageSelect;
        default:          d = 8'h00;
      endcase
    return d;
  endfunction : readReg

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers (ref domain)
  logic [5:0] pinMeta;
  logic [5:0] pinSync;
  logic       sclD;
  logic       sdaD;
  logic       i2cMode;
  logic       sclS;
  logic       sdaS;
  logic       csIdle;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinMeta <= 6'h00;
      pinSync <= 6'h00;
      sclD    <= 1'b0;
      sdaD    <= 1'b0;
    end
    else
    begin
      pinMeta <= {interfaceSelect, addressPinHigh, addressPinLow, chipSelectN, sdioIn,
                  serialClk};
      pinSync <= pinMeta;
      sclD    <= pinSync[0];
      sdaD    <= pinSync[1];
    end
  end
  assign sclS    = pinSync[0];
  assign sdaS    = pinSync[1];
  assign csIdle  = pinSync[2];
  assign i2cMode = pinSync[5];

  // address pins caught once the synchroniser has filled after reset
  logic [1:0] strapCnt;
  logic [1:0] addrPins;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strapCnt <= 2'h0;
      addrPins <= 2'h0;
    end
    else if (strapCnt != 2'h3)
    begin
      strapCnt <= strapCnt + 2'h1;
      if (strapCnt == 2'h2)
        addrPins <= pinSync[4:3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sda timeout
  logic [31:0] tmoCnt;
  logic        tmoLive;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      tmoCnt <= 32'h0;
    else if (!i2cMode || sdaS)
      tmoCnt <= 32'h0;
    else if (!tmoLive)
      tmoCnt <= tmoCnt + 32'h1;
  end
  assign tmoLive = (tmoCnt >= 32'(TIMEOUT_CYCLES));

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic       refWe;
  wr_s        refWr;
  logic       i2cWe;
  wr_s        i2cWr;
  logic       spiWeRef;
  wr_s        spiWr;
  logic [7:0] page;
  logic [4:0] fixedAddr;
  logic       wire3;
  logic       ioVdd;
  logic       tmoFlag;
  regs_s      liveRegs;
  regs_s      published;

  always_comb
  begin
    refWe = i2cMode ? i2cWe : spiWeRef;
    refWr = i2cMode ? i2cWr : spiWr;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      page      <= `PAGE_RESET;
      fixedAddr <= FIXED_ADDR;
      wire3     <= `WIRE3_RESET;
      ioVdd     <= `IO_VDD_RESET;
    end
    else if (refWe)
    begin
      if (refWr.addr == `REG_PAGE)
        page <= refWr.data;
      else
        case ({page, refWr.addr})
          `ADDR_BUS_TARGET: fixedAddr <= refWr.data[6:2];
          `ADDR_WIRE3:      wire3 <= refWr.data[`WIRE3_BIT];
          `ADDR_IO_VDD:     ioVdd <= refWr.data[`IO_VDD_BIT];
          default:          ;
        endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      tmoFlag <= 1'b0;
    else if (tmoLive)
      tmoFlag <= 1'b1;
    else if (refWe && refWr.addr != `REG_PAGE && {page, refWr.addr} == `ADDR_TMO_FLAG
             && !refWr.data[`TMO_BIT])
      tmoFlag <= 1'b0;
  end

  always_comb
  begin
    liveRegs.page               = page;
    liveRegs.busTargetAddress   = {fixedAddr, addrPins};
    liveRegs.timeoutIndicator   = tmoLive;
    liveRegs.timeoutStickyFlag  = tmoFlag;
    liveRegs.spiWireCountSelect = wire3;
    liveRegs.ioVoltageSelect    = ioVdd;
  end
  assign regState = liveRegs;

  // copy for the SPI domain, frozen while a frame is open
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      published <= '0;
    else if (csIdle)
      published <= liveRegs;
  end

  ////////////////////////////////////////////////////////////////////////////
  // I2C target engine (oversampled on ref_clk)
  i2c_phase_e iPhase;
  logic [3:0] iBits;
  logic       iAck;
  logic       iPull;
  logic [7:0] iShift;
  logic [7:0] iOut;
  logic [7:0] ptr;
  logic       hostNack;
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic [7:0] iRead;
  assign sclRise   = sclS & ~sclD;
  assign sclFall   = ~sclS & sclD;
  assign startSeen = sclS & sclD & sdaD & ~sdaS;
  assign stopSeen  = sclS & sclD & ~sdaD & sdaS;
  assign iRead     = readReg(liveRegs, ptr);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      iPhase   <= I_IDLE;
      iBits    <= 4'h0;
      iAck     <= 1'b0;
      iPull    <= 1'b0;
      iShift   <= 8'h00;
      iOut     <= 8'h00;
      ptr      <= 8'h00;
      hostNack <= 1'b0;
      i2cWe    <= 1'b0;
      i2cWr    <= '0;
    end
    else
    begin
      i2cWe <= 1'b0;
      if (!i2cMode || tmoLive || stopSeen)
      begin
        iPhase <= I_IDLE;
        iPull  <= 1'b0;
        iAck   <= 1'b0;
      end
      else if (startSeen)
      begin
        iPhase <= I_DEV;
        iBits  <= 4'h0;
        iAck   <= 1'b0;
        iPull  <= 1'b0;
      end
      else if (iPhase != I_IDLE && sclRise)
      begin
        if (!iAck && iBits != `BYTE_BITS)
        begin
          iShift <= {iShift[6:0], sdaS};
          iBits  <= iBits + 4'h1;
        end
        else if (iAck && iPhase == I_RD)
          hostNack <= sdaS;
      end
      else if (iPhase != I_IDLE && sclFall)
      begin
        if (!iAck && iBits == `BYTE_BITS)
        begin
          iAck <= 1'b1;
          unique case (iPhase)
            I_DEV:
            begin
              hostNack <= 1'b0;
              iPull    <= (iShift[7:1] == liveRegs.busTargetAddress);
              if (iShift[7:1] != liveRegs.busTargetAddress)
                iPhase <= I_IDLE;
              else
                iPhase <= iShift[0] ? I_RD : I_REG;
            end
            I_REG:
            begin
              ptr    <= iShift;
              iPull  <= 1'b1;
              iPhase <= I_WR;
            end
            I_WR:
            begin
              i2cWe <= 1'b1;
              i2cWr <= '{addr: ptr, data: iShift};
              ptr   <= ptr + 8'h01;
              iPull <= 1'b1;
            end
            I_RD:    iPull <= 1'b0;
            default: iPull <= 1'b0;
          endcase
        end
        else if (iAck)
        begin
          iAck  <= 1'b0;
          iBits <= 4'h0;
          iPull <= 1'b0;
          if (iPhase == I_RD)
          begin
            if (hostNack)
              iPhase <= I_IDLE;
            else
            begin
              iOut  <= iRead;
              ptr   <= ptr + 8'h01;
              iPull <= ~iRead[7];
            end
          end
        end
        else if (iPhase == I_RD)
          iPull <= ~iOut[3'(4'h7 - iBits)];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SPI target engine (serialClk domain)
  logic       frameOn;
  logic       spiRstN;
  spi_state_e sState;
  logic [2:0] sBits;
  logic [6:0] sShift;
  logic       sInc;
  logic [7:0] sByte;
  logic [7:0] spiAddr;
  logic       spiToggle;
  logic [7:0] rdShift;
  assign frameOn = ~chipSelectN & ~interfaceSelect;
  assign spiRstN = resetn & frameOn;
  assign sByte   = {sShift, sdioIn};

  always_ff @(posedge serialClk or negedge spiRstN)
  begin
    if (!spiRstN)
    begin
      sState <= S_CMD;
      sBits  <= 3'h0;
      sShift <= 7'h00;
      sInc   <= 1'b0;
    end
    else
    begin
      sShift <= sByte[6:0];
      sBits  <= sBits + 3'h1;
      if (sBits == 3'h7)
        unique case (sState)
          S_CMD:
          begin
            sInc <= sByte[5];
            if (sByte == `CMD_BURST)
              sState <= S_BURSTADDR;
            else
              case (sByte[7:5])
                `CMD_SETADDR:                 sState <= S_SETADDR;
                `CMD_WRITE, `CMD_WRITE_INC:  sState <= S_WRITE;
                `CMD_READ, `CMD_READ_INC:    sState <= S_READ;
                default:                      sState <= S_IGNORE;
              endcase
          end
          S_BURSTADDR: sState <= S_BURST;
          S_BURST:     sState <= S_BURST;
          S_SETADDR, S_WRITE, S_READ, S_IGNORE: sState <= S_IGNORE;
        endcase
    end
  end

  // address and write event survive the end of a frame
  always_ff @(posedge serialClk or negedge resetn)
  begin
    if (!resetn)
    begin
      spiAddr   <= 8'h00;
      spiWr     <= '0;
      spiToggle <= 1'b0;
    end
    else if (frameOn && sBits == 3'h7)
      unique case (sState)
        S_SETADDR, S_BURSTADDR: spiAddr <= sByte;
        S_WRITE, S_BURST:
        begin
          spiWr     <= '{addr: spiAddr, data: sByte};
          spiToggle <= ~spiToggle;
          if (sInc || sState == S_BURST)
            spiAddr <= spiAddr + 8'h01;
        end
        S_READ:
          if (sInc)
            spiAddr <= spiAddr + 8'h01;
        S_CMD, S_IGNORE: ;
      endcase
  end

  always_ff @(negedge serialClk or negedge spiRstN)
  begin
    if (!spiRstN)
      rdShift <= 8'h00;
    else if (sState == S_READ)
      rdShift <= (sBits == 3'h0) ? readReg(published, spiAddr) : {rdShift[6:0], 1'b0};
  end

  // write event into ref domain by toggle
  logic [2:0] togSync;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      togSync <= 3'h0;
    else
      togSync <= {togSync[1:0], spiToggle};
  end
  assign spiWeRef = togSync[2] ^ togSync[1];

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  always_comb
  begin
    sdioOut = i2cMode ? 1'b0 : rdShift[7];
    sdioOe  = i2cMode ? iPull
                      : (frameOn && sState == S_READ && published.spiWireCountSelect);
    sdoOut  = rdShift[7];
    sdoOe   = !i2cMode && frameOn && sState == S_READ && !published.spiWireCountSelect;
  end
endmodule : serial_register_port
`default_nettype wire

/* File: design/serial_register_port_cfg.svh */
// constants and register map of the serial register port
// Notes on behaviour
// - io voltage bit, 0 is 1.8 V
// - three-wire bit, 0 selects four-wire
// - seven-bit bus address readable by software
// - I2C target only, 7-bit, burst increment
// - address is fixed part plus two pins
// - live SDA timeout indicator bit
// - sticky flag, write 0 clears when idle
// - I2C bytes eight bits, MSB first
// - I2C write burst increments register address
// - I2C read burst increments while host acknowledges
// - SPI four-wire separate lines, three-wire shared pin
// - SPI clock ignored while chip select high
// - SPI set address, write, read commands
// - SPI write and read with increment
// - SPI burst write from given start address
// - burst address wraps to zero after 255
// - no SPI burst read command
// - setting changes act at once
`ifndef SERIAL_REGISTER_PORT_CFG_SVH
`define SERIAL_REGISTER_PORT_CFG_SVH
`define REF_CLK_MHZ      100
`define SDA_TIMEOUT_US   25000
`define FIXED_ADDR_RESET 5'h0d
`define PAGE_RESET       8'h00
`define WIRE3_RESET      1'b0
`define IO_VDD_RESET     1'b0
`define REG_PAGE         8'h01
`define ADDR_BUS_TARGET  16'h000b
`define ADDR_TMO_IND     16'h000c
`define ADDR_TMO_FLAG    16'h0011
`define ADDR_WIRE3       16'h002b
`define ADDR_IO_VDD      16'h0943
`define TMO_BIT          5
`define WIRE3_BIT        3
`define IO_VDD_BIT       0
`define CMD_SETADDR      3'h0
`define CMD_WRITE        3'h2
`define CMD_WRITE_INC    3'h3
`define CMD_READ         3'h4
`define CMD_READ_INC     3'h5
`define CMD_BURST        8'he0
`define BYTE_BITS        4'h8
`endif

/* File: design/srp_pkg.sv */
// types shared by the serial register port
package srp_pkg;
  typedef enum logic [2:0] {I_IDLE, I_DEV, I_REG, I_WR, I_RD} i2c_phase_e;
  typedef enum logic [2:0] {S_CMD, S_SETADDR, S_BURSTADDR, S_WRITE, S_BURST, S_READ,
                            S_IGNORE} spi_state_e;
  typedef struct packed {
    logic [7:0] page;
    logic [6:0] busTargetAddress;
    logic       timeoutIndicator;
    logic       timeoutStickyFlag;
    logic       spiWireCountSelect;
    logic       ioVoltageSelect;
  } regs_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wr_s;
endpackage : srp_pkg

/* File: testbench/host.sv */
// host controller model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module host (
  output var logic serialClk,
  output var logic chipSelectN,
  output var logic hostSda,
  output var logic hostDrv,
  input  wire logic sdioLine,
  input  wire logic sdoLine
);
  logic threeWire = 1'b0;
  initial
  begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
    hostSda = 1'b1;
    hostDrv = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // spi byte, msb first, taken on the rising edge
  task automatic sbyte(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      hostDrv = drv;
      hostSda = drv ? tx[i] : ~hostSda;
      #15 rx = {rx[6:0], threeWire ? sdioLine : sdoLine};
      serialClk = 1'b1;
      #15 serialClk = 1'b0;
    end
  endtask : sbyte
  task automatic csOpen;
    #3 chipSelectN = 1'b0;
    #15;
  endtask : csOpen
  task automatic csClose;
    #15 chipSelectN = 1'b1;
    hostDrv = 1'b0;
    #60;
  endtask : csClose
  task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rx);
    csOpen;
    sbyte(cmd, 1'b1, rx);
    sbyte(dat, cmd[7:6] != 2'b10, rx);
    csClose;
  endtask : frame
  ////////////////////////////////////////////////////////////
  // i2c conditions and bytes, open drain
  task automatic start;
    #3 hostSda = 1'b1;
    #100 serialClk = 1'b1;
    #100 hostSda = 1'b0;
    #100 serialClk = 1'b0;
    #100;
  endtask : start
  task automatic stop;
    hostSda = 1'b0;
    #100 serialClk = 1'b1;
    #100 hostSda = 1'b1;
    #100;
  endtask : stop
  task automatic ib(input logic [7:0] tx, input logic ackOut, output logic [7:0] rx,
                    output logic ackIn);
    logic [8:0] bits;
    logic [8:0] sh;
    bits = {tx, ~ackOut};
    for (int i = 8; i >= 0; i--)
    begin
      hostSda = bits[i];
      #100 serialClk = 1'b1;
      #100 sh = {sh[7:0], sdioLine};
      #100 serialClk = 1'b0;
      #100;
    end
    rx = sh[8:1];
    ackIn = ~sh[0];
  endtask : ib
  task automatic sda(input logic v);
    hostSda = v;
  endtask : sda
endmodule : host
`default_nettype wire

/* File: testbench/serial_register_port_assertions.sv */
// assertion checker of the serial register port
`timescale 1ns/1ps
`default_nettype none
module serial_register_port_checker #(
  parameter int         TIMEOUT_CYCLES = 500,
  parameter logic [4:0] FIXED_ADDR     = 5'h0d
) (
  input wire logic           ref_clk,
  input wire logic           resetn,
  input wire logic           chipSelectN,
  input wire logic           interfaceSelect,
  input wire logic           addressPinHigh,
  input wire logic           addressPinLow,
  input wire logic           sdioIn,
  input wire logic           sdioOut,
  input wire logic           sdioOe,
  input wire logic           sdoOe,
  input wire srp_pkg::regs_s regState
);
  import srp_pkg::*;
  logic [31:0] lowCnt;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // length of the current low stretch of the data line
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      lowCnt <= 32'h0000_0000;
    else if (interfaceSelect && !sdioIn && lowCnt != 32'hffff_ffff)
      lowCnt <= lowCnt + 32'h0000_0001;
    else if (!interfaceSelect || sdioIn)
      lowCnt <= 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////
  a_io_reset: assert property ($rose(resetn) |-> !regState.ioVoltageSelect)
    else $error("io select not cleared by reset");
  a_wire_reset: assert property ($rose(resetn) |-> !regState.spiWireCountSelect)
    else $error("wire select not cleared by reset");
  a_addr_pins: assert property ($rose(resetn) |-> ##3
    regState.busTargetAddress == {FIXED_ADDR, addressPinHigh, addressPinLow})
    else $error("bus address not built from pins");
  a_tmo_rise: assert property ($rose(regState.timeoutIndicator) |-> lowCnt >= TIMEOUT_CYCLES)
    else $error("timeout raised early");
  a_tmo_clear: assert property ($rose(sdioIn) && interfaceSelect |-> ##[1:6]
    !regState.timeoutIndicator)
    else $error("timeout not dropped");
  a_flag_set: assert property (regState.timeoutIndicator |-> ##[0:1] regState.timeoutStickyFlag)
    else $error("sticky flag not set");
  a_flag_hold: assert property ($fell(regState.timeoutStickyFlag) |->
    !regState.timeoutIndicator && !$past(regState.timeoutIndicator))
    else $error("sticky flag cleared while live");
  a_cs_quiet: assert property (chipSelectN && !interfaceSelect |-> !sdoOe && !sdioOe)
    else $error("driving while deselected");
  a_wires_excl: assert property (sdoOe |-> !sdioOe && !regState.spiWireCountSelect)
    else $error("wrong data pin driven");
  a_open_drain: assert property (interfaceSelect && sdioOe |-> !sdioOut)
    else $error("data line driven high");
  c_timeout: cover property ($rose(regState.timeoutIndicator));
  c_sdo_read: cover property ($rose(sdoOe));
  c_sdio_read: cover property (sdioOe && !interfaceSelect);
endmodule : serial_register_port_checker
bind serial_register_port serial_register_port_checker #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .FIXED_ADDR(FIXED_ADDR)) u_checker (
  .ref_clk(ref_clk), .resetn(resetn), .chipSelectN(chipSelectN),
  .interfaceSelect(interfaceSelect), .addressPinHigh(addressPinHigh),
  .addressPinLow(addressPinLow), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
  .sdoOe(sdoOe), .regState(regState));
`default_nettype wire

/* File: testbench/serial_register_port_bench.sv */
// self-checking bench of the serial register port
`timescale 1ns/1ps
`default_nettype none
module serial_register_port_bench;
  import srp_pkg::*;
  localparam logic [6:0] DEV = {5'h0d, 2'b10};
  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       interfaceSelect = 1'b0;
  logic       addrHi = 1'b1;
  logic       addrLo = 1'b0;
  logic       serialClk, chipSelectN, hostSda, hostDrv;
  logic       sdioOut, sdioOe, sdoOut, sdoOe;
  wire logic  sdioIn;
  wire logic  sdoLine;
  regs_s      regState;
  logic [7:0] rx;
  logic       ack;
  int         error_cnt = 0;
  int         num_checks = 0;
  assign sdioIn = interfaceSelect ? hostSda & ~(sdioOe & ~sdioOut)
                : sdioOe ? sdioOut : hostDrv ? hostSda : ~hostSda;
  assign sdoLine = sdoOe ? sdoOut : ~sdoOut;
  host u_host (.serialClk(serialClk), .chipSelectN(chipSelectN), .hostSda(hostSda),
               .hostDrv(hostDrv), .sdioLine(sdioIn), .sdoLine(sdoLine));
  serial_register_port #(.TIMEOUT_CYCLES(500), .FIXED_ADDR(5'h0d)) u_serial_register_port (
    .ref_clk(ref_clk), .resetn(resetn), .serialClk(serialClk), .chipSelectN(chipSelectN),
    .interfaceSelect(interfaceSelect), .addressPinHigh(addrHi), .addressPinLow(addrLo),
    .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .regState(regState));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    @(negedge ref_clk);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////
  task automatic tReset;
    chk({7'h0, regState.ioVoltageSelect}, 8'h00);
    chk({7'h0, regState.spiWireCountSelect}, 8'h00);
    chk({1'b0, regState.busTargetAddress}, {1'b0, DEV});
    $display("reset test done");
  endtask : tReset
  task automatic tSpi;
    u_host.frame(8'h1f, 8'h0b, rx);
    u_host.frame(8'h5f, 8'h4c, rx);
    chk({1'b0, regState.busTargetAddress}, 8'h4e);
    u_host.frame(8'h9f, 8'h00, rx);
    chk(rx, 8'h4e);
    u_host.frame(8'h40, 8'h34, rx);
    chk({1'b0, regState.busTargetAddress}, {1'b0, DEV});
    $display("spi command test done");
  endtask : tSpi
  task automatic tInc;
    u_host.frame(8'h00, 8'h2a, rx);
    u_host.frame(8'h60, 8'h00, rx);
    u_host.frame(8'h7f, 8'h08, rx);
    chk({7'h0, regState.spiWireCountSelect}, 8'h01);
    u_host.threeWire = 1'b1;
    u_host.frame(8'h00, 8'h0b, rx);
    u_host.frame(8'ha0, 8'h00, rx);
    chk(rx, {1'b0, DEV});
    u_host.frame(8'hbf, 8'h00, rx);
    chk(rx, 8'h00);
    u_host.frame(8'h00, 8'h2b, rx);
    u_host.frame(8'h40, 8'h00, rx);
    u_host.threeWire = 1'b0;
    $display("increment test done");
  endtask : tInc
  task automatic tBurst;
    u_host.csOpen;
    u_host.sbyte(8'he0, 1'b1, rx);
    u_host.sbyte(8'hff, 1'b1, rx);
    u_host.sbyte(8'h00, 1'b1, rx);
    u_host.sbyte(8'h00, 1'b1, rx);
    u_host.sbyte(8'h09, 1'b1, rx);
    u_host.csClose;
    chk(regState.page, 8'h09);
    u_host.frame(8'h00, 8'h43, rx);
    u_host.frame(8'h40, 8'h01, rx);
    chk({7'h0, regState.ioVoltageSelect}, 8'h01);
    u_host.frame(8'h80, 8'h00, rx);
    chk(rx, 8'h01);
    u_host.frame(8'h00, 8'h01, rx);
    u_host.frame(8'h40, 8'h00, rx);
    $display("burst test done");
  endtask : tBurst
  task automatic tIgnore;
    u_host.sbyte(8'h40, 1'b1, rx);
    u_host.sbyte(8'h07, 1'b1, rx);
    u_host.frame(8'hc0, 8'h05, rx);
    chk(regState.page, 8'h00);
    $display("ignore test done");
  endtask : tIgnore
  task automatic tI2c;
    @(negedge ref_clk);
    interfaceSelect = 1'b1;
    repeat (5) @(negedge ref_clk);
    u_host.start;
    u_host.ib({DEV, 1'b0}, 1'b0, rx, ack);
    chk({7'h0, ack}, 8'h01);
    u_host.ib(8'h2a, 1'b0, rx, ack);
    u_host.ib(8'h00, 1'b0, rx, ack);
    u_host.ib(8'h08, 1'b0, rx, ack);
    u_host.stop;
    chk({7'h0, regState.spiWireCountSelect}, 8'h01);
    u_host.start;
    u_host.ib({DEV, 1'b0}, 1'b0, rx, ack);
    u_host.ib(8'h0b, 1'b0, rx, ack);
    u_host.stop;
    u_host.start;
    u_host.ib({DEV, 1'b1}, 1'b0, rx, ack);
    u_host.ib(8'hff, 1'b1, rx, ack);
    chk(rx, {1'b0, DEV});
    u_host.ib(8'hff, 1'b0, rx, ack);
    chk(rx, 8'h00);
    u_host.stop;
    u_host.start;
    u_host.ib({DEV ^ 7'h01, 1'b0}, 1'b0, rx, ack);
    chk({7'h0, ack}, 8'h00);
    u_host.stop;
    $display("i2c test done");
  endtask : tI2c
  task automatic tTmo;
    u_host.sda(1'b0);
    repeat (600) @(negedge ref_clk);
    chk({7'h0, regState.timeoutIndicator}, 8'h01);
    u_host.sda(1'b1);
    repeat (8) @(negedge ref_clk);
    chk({6'h0, regState.timeoutIndicator, regState.timeoutStickyFlag}, 8'h01);
    u_host.start;
    u_host.ib({DEV, 1'b0}, 1'b0, rx, ack);
    u_host.ib(8'h11, 1'b0, rx, ack);
    u_host.ib(8'h00, 1'b0, rx, ack);
    u_host.stop;
    chk({7'h0, regState.timeoutStickyFlag}, 8'h00);
    $display("timeout test done");
  endtask : tTmo
  task automatic tRestrap;
    @(negedge ref_clk);
    addrHi = 1'b0;
    addrLo = 1'b1;
    resetn = 1'b0;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk({1'b0, regState.busTargetAddress}, {1'b0, DEV[6:2], 2'b01});
    chk({7'h0, regState.ioVoltageSelect}, 8'h00);
    chk({7'h0, regState.spiWireCountSelect}, 8'h00);
    u_host.start;
    u_host.ib({DEV[6:2], 2'b01, 1'b0}, 1'b0, rx, ack);
    chk({7'h0, ack}, 8'h01);
    u_host.stop;
    $display("mid-run reset test done");
  endtask : tRestrap
  ////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #500000;
    error_cnt++;
    summarize;
  end
  initial
  begin
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (5) @(negedge ref_clk);
    tReset;
    tSpi;
    tInc;
    tBurst;
    tIgnore;
    tI2c;
    tTmo;
    tRestrap;
    summarize;
  end
endmodule : serial_register_port_bench
`default_nettype wire
